// file: rtl/arm_ctrl_pkg.sv
// Constants shared by the interval arming control and its delay unit.
`default_nettype none
package arm_ctrl_pkg;

  // Register offsets (byte addresses).
  localparam logic [7:0] CTRL_OFFSET        = 8'h00;
  localparam logic [7:0] START_COUNT_OFFSET = 8'h04;
  localparam logic [7:0] START_TIME_OFFSET  = 8'h08;
  localparam logic [7:0] STOP_COUNT_OFFSET  = 8'h0c;
  localparam logic [7:0] STOP_TIME_OFFSET   = 8'h10;
  localparam logic [7:0] CMD_OFFSET         = 8'h14;
  localparam logic [7:0] STATUS_OFFSET      = 8'h18;

  // Field positions in the control register.
  localparam int START_OUTER_BIT = 0;
  localparam int START_SLOPE_BIT = 1;
  localparam int START_INNER_LSB = 2;
  localparam int STOP_OUTER_BIT  = 4;
  localparam int STOP_SLOPE_BIT  = 5;
  localparam int STOP_INNER_LSB  = 6;
  localparam int FUNC_LSB        = 8;

  // Command and status bits, and the stop time long-range bit.
  localparam int CMD_ARM_BIT        = 0;
  localparam int CMD_ABORT_BIT      = 1;
  localparam int STAT_START_BIT     = 0;
  localparam int STAT_STOP_BIT      = 1;
  localparam int STAT_ERR_BIT       = 2;
  localparam int STAT_BUSY_BIT      = 3;
  localparam int STOP_TIME_LONG_BIT = 31;

  // Value widths and limits.
  localparam int VALUE_W = 27;
  localparam logic [26:0] COUNT_MIN      = 27'h0000001;
  localparam logic [26:0] COUNT_MAX      = 27'h5f5e0ff;
  localparam logic [26:0] SHORT_TIME_MIN = 27'h0000001;
  localparam logic [26:0] SHORT_TIME_MAX = 27'h098967f;
  localparam logic [26:0] LONG_TIME_MIN  = 27'h00003e8;
  localparam logic [26:0] LONG_TIME_MAX  = 27'h0002710;

  // Reset values.
  localparam logic [10:0] CTRL_RESET  = 11'h000;
  localparam logic [26:0] COUNT_RESET = 27'h0000001;
  localparam logic [26:0] TIME_RESET  = 27'h0000001;

  // Timing: clock period, short step and long step in ns, and both steps in clock cycles.
  localparam int CLK_PERIOD_NS    = 100;
  localparam int SHORT_STEP_NS    = 100;
  localparam int LONG_STEP_NS     = 1000000;
  localparam int SHORT_STEP_CYCLES = (SHORT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LONG_STEP_CYCLES  = (LONG_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Source and function encodings.
  typedef enum logic [1:0] {INNER_IMM, INNER_TIMER, INNER_EVENTS, INNER_BAD} inner_src_type;
  typedef enum logic [2:0] {
    FUNC_INTERVAL, FUNC_RISE, FUNC_FALL, FUNC_DUTY, FUNC_WIDTH
  } func_type;
  localparam logic [2:0] FUNC_LAST = 3'h4;

endpackage
`default_nettype wire

// file: rtl/delay_if.sv
// Link between an arm tree and its inner delay unit.
`timescale 1ns/1ns
`default_nettype none
interface delay_if;
  logic        load;
  logic        cancel;
  logic        by_events;
  logic        long_range;
  logic [26:0] target;
  logic        event_pulse;
  logic        done;

  modport ctrl (output load, output cancel, output by_events, output long_range,
                output target, output event_pulse, input done);
  modport unit (input load, input cancel, input by_events, input long_range,
                input target, input event_pulse, output done);
endinterface
`default_nettype wire

// file: rtl/arm_delay_unit.sv
// Inner delay layer: counts timer steps or events, then pulses done.
`timescale 1ns/1ns
`default_nettype none
module arm_delay_unit #(
  parameter int LONG_STEP_CYCLES = arm_ctrl_pkg::LONG_STEP_CYCLES
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Control link.
  delay_if.unit    dl
);
  localparam int DIV_W = $clog2(LONG_STEP_CYCLES + 1);

  logic              busy_reg, busy_next;
  logic              done_reg, done_next;
  logic [26:0]       remain_reg, remain_next;
  logic [DIV_W-1:0]  div_reg, div_next;
  logic              ev_mode_reg, ev_mode_next;
  logic              long_reg, long_next;
  logic              tick;

  assign dl.done = done_reg;

  // Step tick: one per clock in short range, one per divider wrap in long
  // range, or one per event. The divider restarts at load so the first long
  // step is a full one.
  always_comb begin
    div_next = div_reg;
    tick     = 1'b0;
    if (ev_mode_reg) begin
      tick = dl.event_pulse;
    end else if (long_reg) begin
      if (div_reg == DIV_W'(LONG_STEP_CYCLES - 1)) begin
        div_next = '0;
        tick     = 1'b1;
      end else begin
        div_next = div_reg + DIV_W'(1);
      end
    end else begin
      tick = 1'b1;
    end
    busy_next    = busy_reg;
    remain_next  = remain_reg;
    ev_mode_next = ev_mode_reg;
    long_next    = long_reg;
    done_next    = 1'b0;
    if (dl.cancel) begin
      busy_next = 1'b0;
    end else if (dl.load) begin
      busy_next    = 1'b1;
      remain_next  = dl.target;
      ev_mode_next = dl.by_events;
      long_next    = dl.long_range;
      div_next     = '0;
    end else if (busy_reg && tick) begin
      if (remain_reg <= 27'h0000001) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else begin
        remain_next = remain_reg - 27'h0000001;
      end
    end
  end

  // State registers.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy_reg    <= 1'b0;
      done_reg    <= 1'b0;
      remain_reg  <= '0;
      div_reg     <= '0;
      ev_mode_reg <= 1'b0;
      long_reg    <= 1'b0;
    end else begin
      busy_reg    <= busy_next;
      done_reg    <= done_next;
      remain_reg  <= remain_next;
      div_reg     <= div_next;
      ev_mode_reg <= ev_mode_next;
      long_reg    <= long_next;
    end
  end
endmodule
`default_nettype wire

// file: rtl/interval_arm_control.sv
// Start and stop arm trees for interval measurement, with register port.
// Notes on behaviour
// - interval accepts only listed arming combinations.
// - other functions use only outer start layer.
// - start slope resets rising, used when external.
// - start outer source source_a or external, resets source_a.
// - start event count 1..99,999,999, resets 1.
// - start inner source source_a, timer or events.
// - start timer 100 ns steps, resets minimum.
// - stop slope resets rising, used when external.
// - stop outer source source_a or external, resets source_a.
// - stop event count 1..99,999,999, resets 1.
// - stop inner source source_a, timer or events.
// - stop timer short 100 ns, long 1 ms steps.
// - inner layers ignored outside interval function.
`timescale 1ns/1ns
`default_nettype none
module interval_arm_control #(
  parameter int LONG_STEP_CYCLES = arm_ctrl_pkg::LONG_STEP_CYCLES
) (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Register port.
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output var  logic [31:0] rdata,
  // External arm and event pins.
  input  wire logic        ext_arm,
  input  wire logic        count_event,
  // Edge enables and busy flag to the measurement core.
  output var  logic        start_enable,
  output var  logic        stop_enable,
  output var  logic        arm_busy
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_EDGE, ST_DELAY, ST_ACTIVE} tree_state_type;

  // Settings.
  logic [10:0] ctrl_reg, ctrl_next;
  logic [26:0] start_count_reg, start_count_next;
  logic [26:0] start_time_reg, start_time_next;
  logic [26:0] stop_count_reg, stop_count_next;
  logic [26:0] stop_time_reg, stop_time_next;
  logic        stop_long_reg, stop_long_next;
  logic        err_reg, err_next;
  logic [31:0] rdata_reg, rdata_next;

  // Pin synchronisers and edge history.
  logic        arm_s1_reg, arm_s2_reg, arm_d_reg;
  logic        ev_s1_reg, ev_s2_reg, ev_d_reg;
  logic        arm_rise, arm_fall, ev_pulse;

  // Arm trees.
  tree_state_type start_state_reg, start_state_next;
  tree_state_type stop_state_reg, stop_state_next;
  logic        session_reg, session_next;
  logic        start_en_reg, stop_en_reg, busy_reg;

  // Decoded fields.
  logic        start_ext, start_neg, stop_ext, stop_neg, is_interval;
  logic [1:0]  start_inner, stop_inner;
  logic        arm_cmd, abort_cmd, start_edge_hit, stop_edge_hit;
  logic        ctrl_ok, start_count_ok, start_time_ok, stop_count_ok, stop_time_ok;
  logic [10:0] wr_ctrl;
  logic        wr_long;
  logic [26:0] wr_value;

  delay_if start_dl ();
  delay_if stop_dl ();

  arm_delay_unit #(.LONG_STEP_CYCLES(LONG_STEP_CYCLES)) start_delay (
    .ref_clk (ref_clk),
    .rst     (rst),
    .dl      (start_dl.unit)
  );

  arm_delay_unit #(.LONG_STEP_CYCLES(LONG_STEP_CYCLES)) stop_delay (
    .ref_clk (ref_clk),
    .rst     (rst),
    .dl      (stop_dl.unit)
  );

  // Field decode of the held settings.
  assign start_ext   = ctrl_reg[arm_ctrl_pkg::START_OUTER_BIT];
  assign start_neg   = ctrl_reg[arm_ctrl_pkg::START_SLOPE_BIT];
  assign start_inner = ctrl_reg[arm_ctrl_pkg::START_INNER_LSB +: 2];
  assign stop_ext    = ctrl_reg[arm_ctrl_pkg::STOP_OUTER_BIT];
  assign stop_neg    = ctrl_reg[arm_ctrl_pkg::STOP_SLOPE_BIT];
  assign stop_inner  = ctrl_reg[arm_ctrl_pkg::STOP_INNER_LSB +: 2];
  assign is_interval = ctrl_reg[arm_ctrl_pkg::FUNC_LSB +: 3] ==
                       arm_ctrl_pkg::FUNC_INTERVAL;

  // Write data decode and range checks of new settings.
  assign wr_ctrl  = wdata[10:0];
  assign wr_long  = wdata[arm_ctrl_pkg::STOP_TIME_LONG_BIT];
  assign wr_value = wdata[26:0];
  assign ctrl_ok  =
    !(!wr_ctrl[arm_ctrl_pkg::START_OUTER_BIT] &&
      wr_ctrl[arm_ctrl_pkg::START_INNER_LSB +: 2] != arm_ctrl_pkg::INNER_IMM) &&
    wr_ctrl[arm_ctrl_pkg::START_INNER_LSB +: 2] != arm_ctrl_pkg::INNER_BAD &&
    wr_ctrl[arm_ctrl_pkg::STOP_INNER_LSB +: 2] != arm_ctrl_pkg::INNER_BAD &&
    wr_ctrl[arm_ctrl_pkg::FUNC_LSB +: 3] <= arm_ctrl_pkg::FUNC_LAST;
  assign start_count_ok = wr_value >= arm_ctrl_pkg::COUNT_MIN &&
                          wr_value <= arm_ctrl_pkg::COUNT_MAX &&
                          wdata[31:27] == 5'h00;
  assign stop_count_ok  = start_count_ok;
  assign start_time_ok  = wr_value >= arm_ctrl_pkg::SHORT_TIME_MIN &&
                          wr_value <= arm_ctrl_pkg::SHORT_TIME_MAX &&
                          wdata[31:27] == 5'h00;
  assign stop_time_ok   = wdata[30:27] == 4'h0 && (wr_long ?
                          (wr_value >= arm_ctrl_pkg::LONG_TIME_MIN &&
                           wr_value <= arm_ctrl_pkg::LONG_TIME_MAX) :
                          (wr_value >= arm_ctrl_pkg::SHORT_TIME_MIN &&
                           wr_value <= arm_ctrl_pkg::SHORT_TIME_MAX));

  // Commands from the register port.
  assign arm_cmd   = wr_stb && addr == arm_ctrl_pkg::CMD_OFFSET &&
                     wdata[arm_ctrl_pkg::CMD_ARM_BIT];
  assign abort_cmd = wr_stb && addr == arm_ctrl_pkg::CMD_OFFSET &&
                     wdata[arm_ctrl_pkg::CMD_ABORT_BIT];

  // Edges of the synchronised pins; only the second stage is looked at.
  assign arm_rise = arm_s2_reg && !arm_d_reg;
  assign arm_fall = !arm_s2_reg && arm_d_reg;
  assign ev_pulse = ev_s2_reg && !ev_d_reg;
  assign start_edge_hit = start_neg ? arm_fall : arm_rise;
  assign stop_edge_hit  = stop_neg ? arm_fall : arm_rise;

  // Register writes; a rejected write keeps the old value and flags an error.
  always_comb begin
    ctrl_next        = ctrl_reg;
    start_count_next = start_count_reg;
    start_time_next  = start_time_reg;
    stop_count_next  = stop_count_reg;
    stop_time_next   = stop_time_reg;
    stop_long_next   = stop_long_reg;
    err_next         = err_reg;
    if (wr_stb && addr == arm_ctrl_pkg::STATUS_OFFSET && wdata[arm_ctrl_pkg::STAT_ERR_BIT]) begin
      err_next = 1'b0;
    end
    if (wr_stb) begin
      case (addr)
        arm_ctrl_pkg::CTRL_OFFSET: begin
          if (ctrl_ok) begin
            ctrl_next = wr_ctrl;
          end else begin
            err_next = 1'b1;
          end
        end
        arm_ctrl_pkg::START_COUNT_OFFSET: begin
          if (start_count_ok) begin
            start_count_next = wr_value;
          end else begin
            err_next = 1'b1;
          end
        end
        arm_ctrl_pkg::START_TIME_OFFSET: begin
          if (start_time_ok) begin
            start_time_next = wr_value;
          end else begin
            err_next = 1'b1;
          end
        end
        arm_ctrl_pkg::STOP_COUNT_OFFSET: begin
          if (stop_count_ok) begin
            stop_count_next = wr_value;
          end else begin
            err_next = 1'b1;
          end
        end
        arm_ctrl_pkg::STOP_TIME_OFFSET: begin
          if (stop_time_ok) begin
            stop_time_next = wr_value;
            stop_long_next = wr_long;
          end else begin
            err_next = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Start tree: outer qualifier, then inner delay, then active.
  always_comb begin
    start_state_next  = start_state_reg;
    session_next      = session_reg;
    start_dl.load     = 1'b0;
    start_dl.cancel   = abort_cmd || arm_cmd;
    start_dl.by_events = start_inner == arm_ctrl_pkg::INNER_EVENTS;
    start_dl.long_range = 1'b0;
    start_dl.target   = start_dl.by_events ? start_count_reg : start_time_reg;
    start_dl.event_pulse = ev_pulse;
    if (abort_cmd) begin
      start_state_next = ST_IDLE;
      session_next     = 1'b0;
    end else if (arm_cmd) begin
      session_next     = 1'b1;
      start_state_next = start_ext ? ST_WAIT_EDGE : ST_ACTIVE;
    end else begin
      case (start_state_reg)
        ST_WAIT_EDGE: begin
          if (start_edge_hit) begin
            if (!is_interval || start_inner == arm_ctrl_pkg::INNER_IMM) begin
              start_state_next = ST_ACTIVE;
            end else begin
              start_dl.load    = 1'b1;
              start_state_next = ST_DELAY;
            end
          end
        end
        ST_DELAY: begin
          if (start_dl.done) begin
            start_state_next = ST_ACTIVE;
          end
        end
        ST_IDLE: begin
        end
        ST_ACTIVE: begin
        end
        default: begin
          start_state_next = ST_IDLE;
        end
      endcase
    end
  end

  // Stop tree: waits for an active start, then its own two layers.
  always_comb begin
    stop_state_next     = stop_state_reg;
    stop_dl.load        = 1'b0;
    stop_dl.cancel      = abort_cmd || arm_cmd;
    stop_dl.by_events   = stop_inner == arm_ctrl_pkg::INNER_EVENTS;
    stop_dl.long_range  = stop_long_reg && !stop_dl.by_events;
    stop_dl.target      = stop_dl.by_events ? stop_count_reg : stop_time_reg;
    stop_dl.event_pulse = ev_pulse;
    if (abort_cmd || arm_cmd) begin
      stop_state_next = ST_IDLE;
    end else begin
      case (stop_state_reg)
        ST_IDLE: begin
          if (session_reg && start_state_reg == ST_ACTIVE) begin
            if (is_interval && stop_ext) begin
              stop_state_next = ST_WAIT_EDGE;
            end else if (!is_interval || stop_inner == arm_ctrl_pkg::INNER_IMM) begin
              stop_state_next = ST_ACTIVE;
            end else begin
              stop_dl.load    = 1'b1;
              stop_state_next = ST_DELAY;
            end
          end
        end
        ST_WAIT_EDGE: begin
          if (stop_edge_hit) begin
            if (stop_inner == arm_ctrl_pkg::INNER_IMM) begin
              stop_state_next = ST_ACTIVE;
            end else begin
              stop_dl.load    = 1'b1;
              stop_state_next = ST_DELAY;
            end
          end
        end
        ST_DELAY: begin
          if (stop_dl.done) begin
            stop_state_next = ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
        end
        default: begin
          stop_state_next = ST_IDLE;
        end
      endcase
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always_comb begin
    rdata_next = 32'h00000000;
    if (rd_stb) begin
      case (addr)
        arm_ctrl_pkg::CTRL_OFFSET:        rdata_next = {21'h000000, ctrl_reg};
        arm_ctrl_pkg::START_COUNT_OFFSET: rdata_next = {5'h00, start_count_reg};
        arm_ctrl_pkg::START_TIME_OFFSET:  rdata_next = {5'h00, start_time_reg};
        arm_ctrl_pkg::STOP_COUNT_OFFSET:  rdata_next = {5'h00, stop_count_reg};
        arm_ctrl_pkg::STOP_TIME_OFFSET:   rdata_next = {stop_long_reg, 4'h0, stop_time_reg};
        arm_ctrl_pkg::STATUS_OFFSET: begin
          rdata_next[arm_ctrl_pkg::STAT_START_BIT] = start_en_reg;
          rdata_next[arm_ctrl_pkg::STAT_STOP_BIT]  = stop_en_reg;
          rdata_next[arm_ctrl_pkg::STAT_ERR_BIT]   = err_reg;
          rdata_next[arm_ctrl_pkg::STAT_BUSY_BIT]  = busy_reg;
        end
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  // Registers of settings, pins, trees and outputs.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_reg        <= arm_ctrl_pkg::CTRL_RESET;
      start_count_reg <= arm_ctrl_pkg::COUNT_RESET;
      start_time_reg  <= arm_ctrl_pkg::TIME_RESET;
      stop_count_reg  <= arm_ctrl_pkg::COUNT_RESET;
      stop_time_reg   <= arm_ctrl_pkg::TIME_RESET;
      stop_long_reg   <= 1'b0;
      err_reg         <= 1'b0;
      rdata_reg       <= 32'h00000000;
      arm_s1_reg      <= 1'b0;
      arm_s2_reg      <= 1'b0;
      arm_d_reg       <= 1'b0;
      ev_s1_reg       <= 1'b0;
      ev_s2_reg       <= 1'b0;
      ev_d_reg        <= 1'b0;
      start_state_reg <= ST_IDLE;
      stop_state_reg  <= ST_IDLE;
      session_reg     <= 1'b0;
      start_en_reg    <= 1'b0;
      stop_en_reg     <= 1'b0;
      busy_reg        <= 1'b0;
    end else begin
      ctrl_reg        <= ctrl_next;
      start_count_reg <= start_count_next;
      start_time_reg  <= start_time_next;
      stop_count_reg  <= stop_count_next;
      stop_time_reg   <= stop_time_next;
      stop_long_reg   <= stop_long_next;
      err_reg         <= err_next;
      rdata_reg       <= rdata_next;
      arm_s1_reg      <= ext_arm;
      arm_s2_reg      <= arm_s1_reg;
      arm_d_reg       <= arm_s2_reg;
      ev_s1_reg       <= count_event;
      ev_s2_reg       <= ev_s1_reg;
      ev_d_reg        <= ev_s2_reg;
      start_state_reg <= start_state_next;
      stop_state_reg  <= stop_state_next;
      session_reg     <= session_next;
      start_en_reg    <= start_state_next == ST_ACTIVE;
      stop_en_reg     <= stop_state_next == ST_ACTIVE;
      busy_reg        <= session_next && stop_state_next != ST_ACTIVE;
    end
  end

  // Outputs straight from flip-flops.
  assign rdata        = rdata_reg;
  assign start_enable = start_en_reg;
  assign stop_enable  = stop_en_reg;
  assign arm_busy     = busy_reg;
endmodule
`default_nettype wire

// file: verif/arm_signal_source.sv
// Model of the external arm pin and the event pin driven towards the block.
`timescale 1ns/1ns
`default_nettype none
module arm_signal_source (
  // Clock and reset.
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Commands from the bench.
  input  wire logic       arm_level,
  input  wire logic       burst_go,
  input  wire logic [3:0] burst_len,
  // Pins towards the block.
  output var  logic       ext_arm,
  output var  logic       count_event
);
  logic [3:0] left_reg;
  logic [1:0] phase_reg;

  // Follows the commanded arm level and emits event pulses two cycles high, two low.
  always_ff @(posedge ref_clk) begin
    ext_arm <= arm_level;
    if (rst) begin
      left_reg    <= 4'h0;
      phase_reg   <= 2'h0;
      count_event <= 1'b0;
    end else if (burst_go) begin
      left_reg  <= burst_len;
      phase_reg <= 2'h0;
    end else if (left_reg != 4'h0) begin
      count_event <= ~phase_reg[1];
      phase_reg   <= phase_reg + 2'h1;
      if (phase_reg == 2'h3) left_reg <= left_reg - 4'h1;
    end else begin
      count_event <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: verif/arm_ctrl_assertions.sv
// Concurrent checks on the ports of the interval arming control.
`timescale 1ns/1ns
`default_nettype none
module arm_ctrl_assertions (
  // Clock and reset.
  input wire logic        ref_clk,
  input wire logic        rst,
  // Register port.
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [31:0] rdata,
  // Pins and enables.
  input wire logic        ext_arm,
  input wire logic        count_event,
  input wire logic        start_enable,
  input wire logic        stop_enable,
  input wire logic        arm_busy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // A write to the command register may end or restart a session.
  wire cmd_wr = wr_stb && (addr == arm_ctrl_pkg::CMD_OFFSET);

  property p_reset_quiet;
    $fell(rst) |-> !start_enable && !stop_enable && !arm_busy && (rdata == 32'h0);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs not idle after reset");
  property p_rdata_idle;
    !rd_stb |=> rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read cycle");
  property p_cmd_reads_zero;
    rd_stb && (addr == arm_ctrl_pkg::CMD_OFFSET || addr > 8'h18) |=> rdata == 32'h0;
  endproperty
  a_cmd_reads_zero: assert property (p_cmd_reads_zero)
    else $error("command or unmapped read not zero");
  property p_stop_after_start;
    $rose(stop_enable) |-> $past(start_enable) && start_enable;
  endproperty
  a_stop_after_start: assert property (p_stop_after_start)
    else $error("stop armed before start");
  property p_busy_falls;
    $rose(stop_enable) |-> !arm_busy;
  endproperty
  a_busy_falls: assert property (p_busy_falls)
    else $error("busy still high with stop armed");
  property p_start_holds;
    start_enable && !cmd_wr |=> start_enable;
  endproperty
  a_start_holds: assert property (p_start_holds)
    else $error("start arm dropped without command");
  property p_stop_holds;
    stop_enable && !cmd_wr |=> stop_enable;
  endproperty
  a_stop_holds: assert property (p_stop_holds)
    else $error("stop arm dropped without command");
  property p_abort_wins;
    cmd_wr && wdata[arm_ctrl_pkg::CMD_ABORT_BIT] |=> !start_enable && !stop_enable && !arm_busy;
  endproperty
  a_abort_wins: assert property (p_abort_wins)
    else $error("abort did not clear the session");
  property p_status_mirror;
    rd_stb && addr == arm_ctrl_pkg::STATUS_OFFSET |=>
      rdata[3] == $past(arm_busy) && rdata[1:0] == {$past(stop_enable), $past(start_enable)};
  endproperty
  a_status_mirror: assert property (p_status_mirror)
    else $error("status bits differ from enables");
endmodule

bind interval_arm_control arm_ctrl_assertions u_chk (
  .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rdata(rdata), .ext_arm(ext_arm), .count_event(count_event),
  .start_enable(start_enable), .stop_enable(stop_enable), .arm_busy(arm_busy)
);
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the interval arming control.
`timescale 1ns/1ns
`default_nettype none
`define CHECK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic [31:0] rdata;
  logic        ext_arm, count_event, start_enable, stop_enable, arm_busy;
  logic        arm_level = 1'b0;
  logic        burst_go = 1'b0;
  logic [3:0]  burst_len = 4'h0;
  int          num_errors = 0;
  int          total_checks = 0;
  logic [31:0] d;
  int          n;

  // Free-running 10 MHz clock.
  always #50 ref_clk = ~ref_clk;

  interval_arm_control #(.LONG_STEP_CYCLES(10)) dut (
    .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .ext_arm(ext_arm), .count_event(count_event),
    .start_enable(start_enable), .stop_enable(stop_enable), .arm_busy(arm_busy));
  arm_signal_source src (
    .ref_clk(ref_clk), .rst(rst), .arm_level(arm_level), .burst_go(burst_go),
    .burst_len(burst_len), .ext_arm(ext_arm), .count_event(count_event));

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk) begin addr <= a; wdata <= v; wr_stb <= 1'b1; end
    @(posedge ref_clk) wr_stb <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk) begin addr <= a; rd_stb <= 1'b1; end
    @(posedge ref_clk) rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_en(input bit stop, input int lim);
    n = 0;
    while (((stop ? stop_enable : start_enable) !== 1'b1) && n < lim) begin
      @(posedge ref_clk);
      #1 n++;
    end
  endtask
  task automatic events(input logic [3:0] k);
    @(posedge ref_clk) begin burst_go <= 1'b1; burst_len <= k; end
    @(posedge ref_clk) burst_go <= 1'b0;
    repeat (4 * k + 6) @(posedge ref_clk);
    #1;
  endtask

  // Every setting and the status come out of reset at their defaults.
  task automatic t_reset_values;
    logic [7:0]  o[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18};
    logic [31:0] e[6] = '{32'h0, 32'h1, 32'h1, 32'h1, 32'h1, 32'h0};
    for (int i = 0; i < 6; i++) begin
      rd(o[i]);
      `CHECK(d, e[i])
    end
    rd(8'h1c);
    `CHECK(d, 32'h0)
  endtask

  // Out-of-range values and forbidden combinations are refused and flagged.
  task automatic t_refused;
    logic [7:0]  o[9] = '{8'h00, 8'h00, 8'h04, 8'h04, 8'h0c, 8'h10, 8'h10, 8'h08, 8'h08};
    logic [31:0] v[9] = '{32'h4, 32'h500, 32'h0, 32'h5f5e0ff, 32'h5f5e100,
                          32'h800003e8, 32'h800003e7, 32'h98967f, 32'h989680};
    logic [31:0] e[9] = '{32'h0, 32'h0, 32'h1, 32'h5f5e0ff, 32'h1,
                          32'h800003e8, 32'h800003e8, 32'h98967f, 32'h98967f};
    logic        f[9] = '{1, 1, 1, 0, 1, 0, 1, 0, 1};
    for (int i = 0; i < 9; i++) begin
      wr(o[i], v[i]);
      rd(o[i]);
      `CHECK(d, e[i])
      rd(8'h18);
      `CHECK(d[2], f[i])
      wr(8'h18, 32'h4);
    end
  endtask

  // All-source_a arming: start one cycle after the command, stop one later.
  task automatic t_source_a;
    wr(8'h00, 32'h0);
    wr(8'h14, 32'h1);
    `CHECK({start_enable, stop_enable, arm_busy}, 3'b101)
    @(posedge ref_clk);
    #1 `CHECK({start_enable, stop_enable, arm_busy}, 3'b110)
    rd(8'h18);
    `CHECK(d[3:0], 4'h3)
  endtask

  // External start on falling slope, timer delay; external stop after three events.
  task automatic t_external;
    wr(8'h08, 32'h5);
    wr(8'h0c, 32'h3);
    wr(8'h00, 32'h97);
    wr(8'h14, 32'h1);
    `CHECK(start_enable, 1'b0)
    @(posedge ref_clk) arm_level <= 1'b1;
    repeat (12) @(posedge ref_clk);
    #1 `CHECK({start_enable, stop_enable}, 2'b00)
    @(posedge ref_clk) arm_level <= 1'b0;
    wait_en(1'b0, 20);
    `CHECK(n >= 8 && n < 20, 1'b1)
    @(posedge ref_clk) arm_level <= 1'b1;
    repeat (8) @(posedge ref_clk);
    events(4'h2);
    `CHECK(stop_enable, 1'b0)
    events(4'h1);
    `CHECK(stop_enable, 1'b1)
    wr(8'h14, 32'h3);
    `CHECK({start_enable, stop_enable, arm_busy}, 3'b000)
  endtask

  // Other functions ignore the stop inner and outer layers.
  task automatic t_other_functions;
    for (int f = 1; f <= 4; f++) begin
      wr(8'h00, 32'h90 | (f << 8));
      wr(8'h14, 32'h1);
      `CHECK({start_enable, stop_enable}, 2'b10)
      @(posedge ref_clk);
      #1 `CHECK(stop_enable, 1'b1)
    end
  endtask

  // Stop timer delay in both ranges after an source_a start.
  task automatic t_stop_timer;
    wr(8'h10, 32'h3);
    wr(8'h00, 32'h40);
    wr(8'h14, 32'h1);
    wait_en(1'b1, 20);
    `CHECK(n >= 3 && n < 8, 1'b1)
    wr(8'h10, 32'h800003e8);
    wr(8'h14, 32'h1);
    wait_en(1'b1, 10100);
    `CHECK(n >= 10000 && n < 10010, 1'b1)
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Watchdog near twice the ten thousand cycles the scenarios need.
  initial begin
    #2000000;
    num_errors++;
    summarize();
  end

  // Main sequence.
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset_values();
    t_refused();
    t_source_a();
    t_external();
    t_other_functions();
    t_stop_timer();
    summarize();
  end
endmodule
`default_nettype wire
